/* File: wds_watchdog.sv */
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

// Function
// - The watchdog counts edges of its own free-running RC oscillator, not the main clock.
// - A watchdog time-out forces a device reset, a wake-up reset when asleep.
// - A watchdog time-out reset clears the time-out status flag.
// - With the enable fuse at 0 the watchdog is held cleared and never times out.
// - One 8-bit scaler serves either the timer or the watchdog, never both.
// - The assignment bit and 3-bit ratio come from option bits 3 down to 0.
// - Without the scaler the watchdog times out after one 18 ms base period.
// - With the scaler the time-out grows by the ratio, up to 1:128.
// - The clear-watchdog instruction restarts the count and an assigned scaler.
// - The sleep instruction restarts the count and an assigned scaler.
// - The six option bits return to ones on power-on, external and watchdog reset.
// - A time-out restarts the power-up delay, holding the core in reset until it ends.
module wds_watchdog #(
    parameter int unsigned BASE_TICKS  = wds_pkg::WDS_BASE_TICKS,
    parameter int unsigned DELAY_TICKS = wds_pkg::WDS_DELAY_TICKS
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 rc_osc_in,
    input  wire logic                 watchdog_enable_fuse,
    input  wire logic                 external_reset_pin_n,
    input  wire logic                 timer_tick_in,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic                      device_reset_n,
    output logic                      timeout_flag,
    output logic                      timer_scaled_tick,
    output wds_pkg::wds_option_s      option_out,
    output logic                      irq
);
    import wds_pkg::*;

    localparam logic [WDS_CNT_W-1:0] BASE_LAST  = WDS_CNT_W'(BASE_TICKS - 1);
    localparam logic [WDS_CNT_W-1:0] DELAY_LAST = WDS_CNT_W'(DELAY_TICKS - 1);

    // Synchronisers for pins from outside the aclk domain
    logic [2:0]           rc_sync_reg;
    logic [1:0]           fuse_sync_reg;
    logic [1:0]           ext_sync_reg;
    // Bus slave state
    logic                 aw_full_reg;
    logic                 w_full_reg;
    logic [7:0]           aw_addr_reg;
    logic [31:0]          w_data_reg;
    logic [3:0]           w_strb_reg;
    logic                 awready_reg;
    logic                 wready_reg;
    logic                 bvalid_reg;
    logic [1:0]           bresp_reg;
    logic                 arready_reg;
    logic                 rvalid_reg;
    logic [31:0]          rdata_reg;
    logic [1:0]           rresp_reg;
    // Core state
    wds_option_s          option_reg;
    logic                 clr_req_reg;
    logic                 sleep_req_reg;
    logic [WDS_CNT_W-1:0] base_cnt_reg;
    logic [7:0]           scaler_reg;
    logic [WDS_CNT_W-1:0] delay_cnt_reg;
    logic                 device_reset_n_reg;
    logic                 timeout_flag_reg;
    logic                 asleep_reg;
    logic                 tick_out_reg;
    wds_irq_t             irq_stat_reg;
    wds_irq_t             irq_en_reg;
    logic                 irq_reg;

    // Only the second and third stages feed logic
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rc_sync_reg   <= 3'h0;
            fuse_sync_reg <= 2'h0;
            ext_sync_reg  <= 2'h0;
        end
        else
        begin
            rc_sync_reg   <= {rc_sync_reg[1:0], rc_osc_in};
            fuse_sync_reg <= {fuse_sync_reg[0], watchdog_enable_fuse};
            ext_sync_reg  <= {ext_sync_reg[0], external_reset_pin_n};
        end
    end

    wire rc_tick  = rc_sync_reg[1] & ~rc_sync_reg[2];
    wire fuse_on  = fuse_sync_reg[1];
    wire ext_high = ext_sync_reg[1];

    // Bus handshakes; each address and data phase is taken independently
    wire aw_take      = s_axi_awvalid & awready_reg;
    wire w_take       = s_axi_wvalid & wready_reg;
    wire wr_go        = aw_full_reg & w_full_reg & ~bvalid_reg;
    wire aw_full_next = (aw_full_reg | aw_take) & ~wr_go;
    wire w_full_next  = (w_full_reg | w_take) & ~wr_go;
    wire bvalid_next  = wr_go | (bvalid_reg & ~s_axi_bready);
    wire ar_take      = s_axi_arvalid & arready_reg;
    wire rvalid_next  = ar_take | (rvalid_reg & ~s_axi_rready);

    // Write decode on the word address
    wire [7:0] wr_word   = {aw_addr_reg[7:2], 2'h0};
    wire       wr_lane0  = wr_go & w_strb_reg[0];
    wire       opt_wr    = wr_lane0 & (wr_word == WDS_OFS_OPTION);
    wire       clr_wr    = wr_lane0 & (wr_word == WDS_OFS_IRQ_CLR);
    wire       en_wr     = wr_lane0 & (wr_word == WDS_OFS_IRQ_EN);
    wire       ctrl_wr   = wr_lane0 & (wr_word == WDS_OFS_CTRL);
    wire       wr_mapped = (wr_word == WDS_OFS_OPTION) | (wr_word == WDS_OFS_STATUS)
                         | (wr_word == WDS_OFS_IRQ_STAT) | (wr_word == WDS_OFS_IRQ_CLR)
                         | (wr_word == WDS_OFS_IRQ_EN) | (wr_word == WDS_OFS_CTRL)
                         | (wr_word == WDS_OFS_SCALER);

    // Read decode; option and clear registers are write-only and read zero
    wire [7:0]   rd_word  = {s_axi_araddr[7:2], 2'h0};
    wds_status_s status_view;
    assign status_view = '{delay_active: ~device_reset_n_reg, asleep: asleep_reg,
                           fuse_on: fuse_on, timeout_flag: timeout_flag_reg};
    wire         rd_hit   = (rd_word == WDS_OFS_OPTION) | (rd_word == WDS_OFS_STATUS)
                          | (rd_word == WDS_OFS_IRQ_STAT) | (rd_word == WDS_OFS_IRQ_CLR)
                          | (rd_word == WDS_OFS_IRQ_EN) | (rd_word == WDS_OFS_CTRL)
                          | (rd_word == WDS_OFS_SCALER);
    wire [31:0]  rd_data  = (rd_word == WDS_OFS_STATUS)   ? {28'h0, status_view} :
                            (rd_word == WDS_OFS_IRQ_STAT) ? {29'h0, irq_stat_reg} :
                            (rd_word == WDS_OFS_IRQ_EN)   ? {29'h0, irq_en_reg} :
                            (rd_word == WDS_OFS_SCALER)   ? {24'h0, scaler_reg} : 32'h0;

    // Bus slave registers; ready drops while a phase is held or a response waits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0;
            w_strb_reg  <= 4'h0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= WDS_RESP_OKAY;
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0;
            rresp_reg   <= WDS_RESP_OKAY;
        end
        else
        begin
            aw_full_reg <= aw_full_next;
            w_full_reg  <= w_full_next;
            awready_reg <= ~aw_full_next & ~bvalid_next;
            wready_reg  <= ~w_full_next & ~bvalid_next;
            bvalid_reg  <= bvalid_next;
            arready_reg <= ~rvalid_next;
            rvalid_reg  <= rvalid_next;
            if (aw_take)
                aw_addr_reg <= s_axi_awaddr;
            if (w_take)
            begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go)
                bresp_reg <= wr_mapped ? WDS_RESP_OKAY : WDS_RESP_SLVERR;
            if (ar_take)
            begin
                rdata_reg <= rd_data;
                rresp_reg <= rd_hit ? WDS_RESP_OKAY : WDS_RESP_SLVERR;
            end
        end
    end

    // Watchdog counting; instructions are ignored while the core is held in reset
    wire       assign_wdt  = option_reg.scaler_assign_bit;
    wire [2:0] ratio       = option_reg.scale_ratio_field;
    wire       clr_go      = clr_req_reg & device_reset_n_reg;
    wire       sleep_go    = sleep_req_reg & device_reset_n_reg;
    wire       restart     = clr_go | sleep_go | ~device_reset_n_reg | ~fuse_on;
    wire       base_last   = (base_cnt_reg == BASE_LAST);
    wire       base_expire = rc_tick & base_last & ~restart;
    wire [7:0] wd_mask     = (8'h01 << ratio) - 8'h01;
    wire       wd_full     = (scaler_reg & wd_mask) == wd_mask;
    wire       wd_fire     = base_expire & (~assign_wdt | wd_full);
    // Timer side prescales 1:2 to 1:256 off the same counter
    wire [7:0] tmr_mask    = {wd_mask[6:0], 1'b1};
    wire       tmr_wrap    = timer_tick_in & ~assign_wdt
                           & ((scaler_reg & tmr_mask) == tmr_mask);
    wire       delay_last  = (delay_cnt_reg == DELAY_LAST);
    wire       release_evt = ~device_reset_n_reg & ext_high & rc_tick & delay_last;
    wire       opt_reload  = ~ext_high | wd_fire;

    // Base period counter runs only on oscillator edges
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            base_cnt_reg <= '0;
        else if (restart)
            base_cnt_reg <= '0;
        else if (rc_tick)
            base_cnt_reg <= base_last ? '0 : base_cnt_reg + 1'b1;
    end

    // Shared scaler; cleared on reassignment so no stale count leaks across
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            scaler_reg <= 8'h00;
        else if (opt_wr || opt_reload)
            scaler_reg <= 8'h00;
        else if (assign_wdt)
        begin
            if (restart || wd_fire)
                scaler_reg <= 8'h00;
            else if (base_expire)
                scaler_reg <= scaler_reg + 8'h01;
        end
        else if (timer_tick_in)
            scaler_reg <= scaler_reg + 8'h01;
    end

    // Power-up delay; a time-out starts it over and holds the core meanwhile
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            delay_cnt_reg      <= '0;
            device_reset_n_reg <= 1'b0;
        end
        else if (!ext_high || wd_fire)
        begin
            delay_cnt_reg      <= '0;
            device_reset_n_reg <= 1'b0;
        end
        else if (release_evt)
        begin
            delay_cnt_reg      <= '0;
            device_reset_n_reg <= 1'b1;
        end
        else if (!device_reset_n_reg && rc_tick)
            delay_cnt_reg <= delay_cnt_reg + 1'b1;
    end

    // Option register, instruction pulses, flags
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            option_reg       <= WDS_OPT_RESET;
            clr_req_reg      <= 1'b0;
            sleep_req_reg    <= 1'b0;
            timeout_flag_reg <= 1'b1;
            asleep_reg       <= 1'b0;
            tick_out_reg     <= 1'b0;
        end
        else
        begin
            if (opt_reload)
                option_reg <= WDS_OPT_RESET;
            else if (opt_wr)
                option_reg <= {2'h0, w_data_reg[5:0]};
            clr_req_reg   <= ctrl_wr & w_data_reg[WDS_CTRL_CLR_BIT];
            sleep_req_reg <= ctrl_wr & w_data_reg[WDS_CTRL_SLEEP_BIT];
            if (wd_fire)
                timeout_flag_reg <= 1'b0;
            else if (clr_go || sleep_go)
                timeout_flag_reg <= 1'b1;
            if (wd_fire || !ext_high)
                asleep_reg <= 1'b0;
            else if (sleep_go)
                asleep_reg <= 1'b1;
            tick_out_reg <= tmr_wrap;
        end
    end

    // Sticky events; an event in the clearing cycle survives
    wds_irq_t irq_events;
    assign irq_events = {release_evt, wd_fire & asleep_reg, wd_fire & ~asleep_reg};
    wds_irq_t irq_stat_next;
    wds_irq_t irq_en_next;
    assign irq_stat_next = (irq_stat_reg & ~(clr_wr ? w_data_reg[2:0] : 3'h0)) | irq_events;
    assign irq_en_next   = en_wr ? w_data_reg[2:0] : irq_en_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat_reg <= WDS_IRQ_RESET;
            irq_en_reg   <= WDS_IRQ_RESET;
            irq_reg      <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= irq_stat_next;
            irq_en_reg   <= irq_en_next;
            irq_reg      <= |(irq_stat_next & irq_en_next);
        end
    end

    assign s_axi_awready     = awready_reg;
    assign s_axi_wready      = wready_reg;
    assign s_axi_bvalid      = bvalid_reg;
    assign s_axi_bresp       = bresp_reg;
    assign s_axi_arready     = arready_reg;
    assign s_axi_rvalid      = rvalid_reg;
    assign s_axi_rdata       = rdata_reg;
    assign s_axi_rresp       = rresp_reg;
    assign device_reset_n    = device_reset_n_reg;
    assign timeout_flag      = timeout_flag_reg;
    assign timer_scaled_tick = tick_out_reg;
    assign option_out        = option_reg;
    assign irq               = irq_reg;

    // Checks on the watchdog behaviour
    default clocking wds_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_count_on_rc: assert property ($changed(base_cnt_reg) |-> $past(rc_tick || restart))
        else $error("base count moved without an oscillator edge");
    a_fire_resets_core: assert property (wd_fire |=> !device_reset_n_reg [*2])
        else $error("time-out did not hold the core in reset");
    a_fire_clears_flag: assert property (wd_fire |=> !timeout_flag_reg)
        else $error("time-out flag not cleared");
    a_fuse_off_quiet: assert property (!fuse_on |-> !wd_fire ##1 base_cnt_reg == '0)
        else $error("disabled watchdog is counting");
    a_scaler_exclusive: assert property (assign_wdt && $past(assign_wdt) |-> !tick_out_reg)
        else $error("timer got scaled ticks while scaler serves watchdog");
    a_option_write: assert property (opt_wr && !opt_reload
                                     |=> option_reg == {2'h0, w_data_reg[5:0]})
        else $error("option write not stored");
    a_plain_period: assert property (wd_fire && !assign_wdt |-> base_last && rc_tick)
        else $error("unscaled time-out off the base period");
    a_scaled_period: assert property (wd_fire && assign_wdt |-> scaler_reg == wd_mask)
        else $error("scaled time-out before the ratio was reached");
    a_clear_restarts: assert property (clr_go |=> base_cnt_reg == '0 && !wd_fire)
        else $error("clear instruction did not restart the count");
    a_sleep_restarts: assert property (sleep_go && ext_high
                                       |=> asleep_reg && base_cnt_reg == '0)
        else $error("sleep instruction did not restart the count");
    a_option_reload: assert property (opt_reload |=> option_reg == WDS_OPT_RESET)
        else $error("option not reloaded on reset");
    a_delay_release: assert property ($rose(device_reset_n_reg)
                                      |-> $past(delay_cnt_reg) == DELAY_LAST)
        else $error("core released before the delay ended");
    a_ratio_decode: assert property (assign_wdt && ratio == 3'h7 |-> wd_mask == 8'h7f)
        else $error("ratio decode wrong");

    c_fire_awake: cover property (wd_fire && !asleep_reg);
    c_fire_asleep: cover property (wd_fire && asleep_reg);
    c_scaled_max: cover property (wd_fire && assign_wdt && ratio == 3'h7);
    c_timer_tick: cover property (tick_out_reg);

endmodule : wds_watchdog
`default_nettype wire

/* File: wds_pkg.sv */
`default_nettype none
package wds_pkg;

    // Watchdog base period and the free-running RC oscillator it counts
    localparam int unsigned WDS_PERIOD_US   = 18000;
    localparam int unsigned WDS_RC_OSC_KHZ  = 1000;
    localparam int unsigned WDS_BASE_TICKS  = WDS_PERIOD_US * WDS_RC_OSC_KHZ / 1000;
    // Power-up delay also lasts one nominal 18 ms period
    localparam int unsigned WDS_DELAY_US    = 18000;
    localparam int unsigned WDS_DELAY_TICKS = WDS_DELAY_US * WDS_RC_OSC_KHZ / 1000;
    localparam int unsigned WDS_CNT_W       = 24;

    // Register byte offsets
    localparam logic [7:0] WDS_OFS_OPTION   = 8'h00;
    localparam logic [7:0] WDS_OFS_STATUS   = 8'h04;
    localparam logic [7:0] WDS_OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] WDS_OFS_IRQ_CLR  = 8'h0c;
    localparam logic [7:0] WDS_OFS_IRQ_EN   = 8'h10;
    localparam logic [7:0] WDS_OFS_CTRL     = 8'h14;
    localparam logic [7:0] WDS_OFS_SCALER   = 8'h18;

    // Reset values
    localparam logic [7:0] WDS_OPT_RESET    = 8'h3f;
    localparam logic [2:0] WDS_IRQ_RESET    = 3'h0;

    // Field positions
    localparam int unsigned WDS_CTRL_CLR_BIT   = 0;
    localparam int unsigned WDS_CTRL_SLEEP_BIT = 1;
    localparam int unsigned WDS_IRQ_WD_RESET   = 0;
    localparam int unsigned WDS_IRQ_WAKE       = 1;
    localparam int unsigned WDS_IRQ_RELEASE    = 2;

    // Bus responses
    localparam logic [1:0] WDS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] WDS_RESP_SLVERR = 2'h2;

    typedef logic [2:0] wds_irq_t;

    typedef struct packed {
        logic [1:0] unused;
        logic [1:0] tmr_src;
        logic       scaler_assign_bit;
        logic [2:0] scale_ratio_field;
    } wds_option_s;

    typedef struct packed {
        logic delay_active;
        logic asleep;
        logic fuse_on;
        logic timeout_flag;
    } wds_status_s;

endpackage : wds_pkg
`default_nettype wire

/* File: wds_testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import wds_pkg::*;
    localparam int BT = 4;
    localparam int DT = 4;
    logic        aclk                 = 1'b0;
    logic        aresetn              = 1'b0;
    logic        rc_osc_in            = 1'b0;
    logic        watchdog_enable_fuse = 1'b1;
    logic        external_reset_pin_n = 1'b1;
    logic        timer_tick_in        = 1'b0;
    logic [7:0]  s_axi_awaddr         = 8'h00;
    logic        s_axi_awvalid        = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata          = 32'h0;
    logic [3:0]  s_axi_wstrb          = 4'hf;
    logic        s_axi_wvalid         = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready         = 1'b0;
    logic [7:0]  s_axi_araddr         = 8'h00;
    logic        s_axi_arvalid        = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready         = 1'b0;
    logic        device_reset_n;
    logic        timeout_flag;
    logic        timer_scaled_tick;
    wds_option_s option_out;
    logic        irq;
    logic [2:0]  rc_div               = 3'h0;
    int          rc_edges             = 0;
    int          low_cycles           = 0;
    int          ticks                = 0;
    int          fails                = 0;
    int          checks               = 0;
    int          e;
    int          c0;
    logic [31:0] rd;
    logic [1:0]  rsp;
    logic [7:0]  opts [5]             = '{8'h00, 8'h08, 8'h09, 8'h0b, 8'h0f};
    int          mult [5]             = '{1, 1, 2, 8, 128};

    wds_watchdog #(.BASE_TICKS(BT), .DELAY_TICKS(DT)) u_wds_watchdog (
        .aclk(aclk), .aresetn(aresetn), .rc_osc_in(rc_osc_in),
        .watchdog_enable_fuse(watchdog_enable_fuse),
        .external_reset_pin_n(external_reset_pin_n), .timer_tick_in(timer_tick_in),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .device_reset_n(device_reset_n), .timeout_flag(timeout_flag),
        .timer_scaled_tick(timer_scaled_tick), .option_out(option_out), .irq(irq));

    always #5 aclk = ~aclk;

    // Slow RC stand-in, four cycles high and four low, plus event counters
    always @(posedge aclk)
    begin
        rc_div <= rc_div + 3'h1;
        rc_osc_in <= rc_div[2];
        if (rc_div == 3'h4) rc_edges <= rc_edges + 1;
        if (device_reset_n === 1'b0) low_cycles <= low_cycles + 1;
        if (timer_scaled_tick === 1'b1) ticks <= ticks + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    begin
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    end
    endtask : check

    task automatic close_out;
    begin
        $display("counts: %0d checks, %0d fails", checks, fails);
        if (fails == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask : close_out

    task automatic give_up(input string what);
    begin
        fails++;
        $display("unexpected at %0t: %s never came", $time, what);
        close_out();
    end
    endtask : give_up

    // Write: address and data offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
    begin
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1 && n < 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        if (n >= 50) give_up("write response");
    end
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
    begin
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1 && n < 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        if (n >= 50) give_up("read data");
    end
    endtask : axi_read

    // Counts RC edges until the core leaves reset
    task automatic wait_release;
        int n;
        int e0;
    begin
        n = 0;
        e0 = rc_edges;
        while (device_reset_n !== 1'b1 && n < 2000)
        begin
            @(posedge aclk);
            n++;
        end
        if (n >= 2000)
            give_up("core release");
        else
        begin
            e = rc_edges - e0;
            check(32'(e >= DT - 1 && e <= DT + 1), 32'h1, "delay length");
        end
    end
    endtask : wait_release

    // Option changed with the fuse low, so the watchdog restarts from zero
    task automatic set_opt(input logic [7:0] opt);
    begin
        watchdog_enable_fuse <= 1'b0;
        repeat (4) @(posedge aclk);
        axi_write(WDS_OFS_OPTION, {24'h0, opt}, rsp);
        check({24'h0, option_out}, {24'h0, opt}, "option out");
        watchdog_enable_fuse <= 1'b1;
    end
    endtask : set_opt

    task automatic wait_fall(input int exp);
        int n;
        int e0;
    begin
        n = 0;
        e0 = rc_edges;
        while (device_reset_n === 1'b1 && n < 20000)
        begin
            @(posedge aclk);
            n++;
        end
        if (n >= 20000)
            give_up("time-out");
        else
        begin
            n = rc_edges - e0;
            check(32'(n >= exp - 1 && n <= exp + 1), 32'h1, "period");
            check({31'h0, timeout_flag}, 32'h0, "flag after time-out");
            check({24'h0, option_out}, 32'h3f, "option after time-out");
        end
    end
    endtask : wait_fall

    initial
    begin
        repeat (10) @(posedge aclk);
        check({24'h0, option_out}, 32'h3f, "option at reset");
        check({29'h0, timeout_flag, device_reset_n, irq}, 32'h4, "reset outputs");
        aresetn <= 1'b1;
        wait_release();
        axi_read(WDS_OFS_IRQ_STAT, rd, rsp);
        check(rd, 32'h4, "irq status");
        axi_write(WDS_OFS_IRQ_EN, 32'h1, rsp);
        check({31'h0, irq}, 32'h0, "masked irq");
        axi_read(WDS_OFS_OPTION, rd, rsp);
        check({rd[29:0], rsp}, 32'h0, "option read");
        axi_read(8'h1c, rd, rsp);
        check({rd[29:0], rsp}, {30'h0, WDS_RESP_SLVERR}, "unmapped read");
        axi_write(8'h1c, 32'h1, rsp);
        check({30'h0, rsp}, {30'h0, WDS_RESP_SLVERR}, "unmapped write");
        $display("test registers done");
        // No scaler, then ratios 1:1, 1:2, 1:8 and the 1:128 boundary
        for (int i = 0; i < 5; i++)
        begin
            set_opt(opts[i]);
            wait_fall(BT * mult[i]);
            check({31'h0, irq}, 32'h1, "irq on time-out");
            axi_write(WDS_OFS_IRQ_CLR, 32'h1, rsp);
            check({31'h0, irq}, 32'h0, "irq cleared");
            wait_release();
        end
        $display("test time-out lengths done");
        set_opt(8'h00);
        c0 = low_cycles;
        repeat (12)
        begin
            axi_write(WDS_OFS_CTRL, 32'h1, rsp);
            repeat (8) @(posedge aclk);
        end
        check(32'(low_cycles - c0), 32'h0, "reset despite clears");
        check({31'h0, timeout_flag}, 32'h1, "flag after clear");
        $display("test clear instruction done");
        set_opt(8'h08);
        axi_write(WDS_OFS_IRQ_CLR, 32'h7, rsp);
        axi_write(WDS_OFS_CTRL, 32'h2, rsp);
        axi_read(WDS_OFS_STATUS, rd, rsp);
        check(rd, 32'h7, "status asleep");
        wait_fall(BT);
        wait_release();
        axi_read(WDS_OFS_IRQ_STAT, rd, rsp);
        check(rd, 32'h6, "wake-up reset seen");
        $display("test sleep done");
        watchdog_enable_fuse <= 1'b0;
        repeat (4) @(posedge aclk);
        c0 = low_cycles;
        axi_write(WDS_OFS_OPTION, 32'h01, rsp);
        axi_read(WDS_OFS_STATUS, rd, rsp);
        check({31'h0, rd[1]}, 32'h0, "fuse off in status");
        for (int i = 0; i < 2; i++)
        begin
            e = ticks;
            timer_tick_in <= 1'b1;
            repeat (32) @(posedge aclk);
            timer_tick_in <= 1'b0;
            repeat (4) @(posedge aclk);
            check(32'(ticks - e), (i == 0) ? 32'h8 : 32'h0, "scaled ticks");
            axi_write(WDS_OFS_OPTION, 32'h09, rsp);
        end
        repeat (200) @(posedge aclk);
        check(32'(low_cycles - c0), 32'h0, "reset with fuse off");
        external_reset_pin_n <= 1'b0;
        repeat (6) @(posedge aclk);
        check({23'h0, device_reset_n, option_out}, 32'h3f, "pin reset");
        external_reset_pin_n <= 1'b1;
        wait_release();
        $display("test fuse, timer and pin done");
        close_out();
    end
endmodule : testbench
`default_nettype wire
